/* File: hdl/input_capture_pkg.sv */
// Constants shared by the input capture block: register map, field
// positions, mode codes and sizes.
// Assumes a 16-bit register port with word-aligned byte addresses.
package input_capture_pkg;

   localparam int unsigned NUM_CHANNELS = 8;
   localparam int unsigned FIFO_DEPTH   = 4;
   localparam int unsigned TS_W         = 16;
   localparam int unsigned ADDR_W       = 8;
   localparam int unsigned DATA_W       = 16;

   // Per channel: control word then buffer word, stride of two words
   localparam logic [7:0] CH_CTRL_OFS   = 8'h00;
   localparam logic [7:0] CH_BUF_OFS    = 8'h04;
   localparam int unsigned CH_SHIFT     = 3;
   localparam logic [7:0] IRQ_STAT_ADDR = 8'h40;
   localparam logic [7:0] IRQ_EN_ADDR   = 8'h44;
   localparam logic [7:0] IRQ_CLR_ADDR  = 8'h48;

   // Control register fields
   localparam int unsigned IDLE_STOP_BIT = 13;
   localparam int unsigned TB_SEL_BIT    = 7;
   localparam int unsigned CPI_LSB       = 5;
   localparam int unsigned OVF_BIT       = 4;
   localparam int unsigned BNE_BIT       = 3;
   localparam logic [15:0] CTRL_WR_MASK  = 16'h20e7;
   localparam logic [15:0] CTRL_RESET    = 16'h0000;

   // Capture mode codes
   localparam logic [2:0] MODE_OFF    = 3'h0;
   localparam logic [2:0] MODE_EVERY  = 3'h1;
   localparam logic [2:0] MODE_FALL   = 3'h2;
   localparam logic [2:0] MODE_RISE   = 3'h3;
   localparam logic [2:0] MODE_DIV4   = 3'h4;
   localparam logic [2:0] MODE_DIV16  = 3'h5;
   localparam logic [2:0] MODE_UNUSED = 3'h6;
   localparam logic [2:0] MODE_WAKE   = 3'h7;

   // Prescaler terminal counts
   localparam logic [3:0] PRE_TC_4  = 4'h3;
   localparam logic [3:0] PRE_TC_16 = 4'hf;

endpackage : input_capture_pkg

/* File: hdl/input_capture.sv */
// Bank of input capture channels with 4-entry timestamp buffers and a
// shared interrupt status / enable / clear register set.
// Assumes the time base counts are on core_clk; pins are asynchronous.
//
// Overview of operation
// RULE_01 - A qualifying pin event stores the selected 16-bit time base count.
// RULE_02 - Mode 001 captures both edges, 010 falling, 011 rising.
// RULE_03 - Mode 100 captures every 4th rising edge, 101 every 16th.
// RULE_04 - Mode 000 turns the channel off.
// RULE_05 - Mode 110 is unused and behaves as off.
// RULE_06 - Mode 111: rising edge interrupts only in sleep or idle.
// RULE_07 - Interrupt after one, two, three or four captures per field.
// RULE_08 - In both-edge mode every capture interrupts regardless of count field.
// RULE_09 - Captured values sit in a four-deep 16-bit FIFO.
// RULE_10 - Read-only not-empty flag shows unread values remain.
// RULE_11 - Read-only overflow flag set on overflow, cleared by hardware.
// RULE_12 - Select bit 1 captures time base A, 0 time base B.
// RULE_13 - Idle-stop bit halts the channel while the CPU idles.
// RULE_14 - Capture events in sleep or idle raise a wake-up.
// RULE_15 - Software using DMA sets count field to 00; channels one, two only.
// RULE_16 - Up to eight independent channels, each with control and buffer.
// RULE_17 - Buffer read returns the oldest value and removes it.
// RULE_18 - Capture into a full buffer sets overflow, keeps stored entries.
//
// Implementation choices: the plain strobed port and the placing of the registers.
module input_capture #(
   parameter int unsigned NUM_CHANNELS = input_capture_pkg::NUM_CHANNELS,
   parameter int unsigned FIFO_DEPTH   = input_capture_pkg::FIFO_DEPTH
) (
   input  wire logic                    core_clk,          // System clock
   input  wire logic                    rstn,              // Async reset, active low
   input  wire logic                    clk_en,            // Freezes all state when low
   input  wire logic [NUM_CHANNELS-1:0] capture_input_pin, // Asynchronous capture inputs
   input  wire logic [15:0]             time_base_a_count, // First time base
   input  wire logic [15:0]             time_base_b_count, // Second time base
   input  wire logic                    cpu_idle,          // CPU is in idle
   input  wire logic                    cpu_sleep,         // CPU is in sleep
   input  wire logic [7:0]              bus_addr,          // Register byte address
   input  wire logic [15:0]             bus_wdata,         // Write data
   input  wire logic                    bus_wr,            // Write strobe
   input  wire logic                    bus_rd,            // Read strobe
   output logic      [15:0]             bus_rdata_q,       // Read data, cycle after strobe
   output logic                         irq_q,             // Level interrupt
   output logic                         wake_q             // Wake-up pulse
);

   localparam int unsigned PTR_W = $clog2(FIFO_DEPTH);
   localparam int unsigned CNT_W = PTR_W + 1;
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(FIFO_DEPTH);

   // Event qualification per mode
   function automatic logic edge_hit(input logic [2:0] mode, input logic rise,
                                     input logic fall, input logic pre_tc);
      unique case (mode)
         input_capture_pkg::MODE_EVERY: edge_hit = rise | fall;  // see RULE_02
         input_capture_pkg::MODE_FALL:  edge_hit = fall;         // see RULE_02
         input_capture_pkg::MODE_RISE:  edge_hit = rise;         // see RULE_02
         input_capture_pkg::MODE_DIV4,
         input_capture_pkg::MODE_DIV16: edge_hit = rise & pre_tc; // see RULE_03
         default:                       edge_hit = 1'b0;         // see RULE_04
      endcase
   endfunction : edge_hit

   // Buffer pointer step with wrap at the last entry
   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] ptr);
      if (ptr == PTR_W'(FIFO_DEPTH - 1)) begin
         ptr_inc = '0;
      end else begin
         ptr_inc = ptr + PTR_W'(1);
      end
   endfunction : ptr_inc

   // Fill level after one cycle of writes and reads
   function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] cnt,
                                                  input logic             inc,
                                                  input logic             dec);
      if (inc && !dec) begin
         cnt_step = cnt + CNT_W'(1);
      end else if (dec && !inc) begin
         cnt_step = cnt - CNT_W'(1);
      end else begin
         cnt_step = cnt;
      end
   endfunction : cnt_step

   ////////////////////////////////////////////////////////////////////////////
   // Register port decode

   wire [4:0] ch_sel   = bus_addr[7:input_capture_pkg::CH_SHIFT];
   wire       ch_ok    = (ch_sel < 5'(NUM_CHANNELS)) && (bus_addr[1:0] == 2'h0);
   wire [2:0] ch_word  = {bus_addr[2], 2'h0};
   wire       ctrl_sel = ch_ok && ({5'h0, ch_word} == input_capture_pkg::CH_CTRL_OFS);
   wire       buf_sel  = ch_ok && ({5'h0, ch_word} == input_capture_pkg::CH_BUF_OFS);
   wire       stat_sel = bus_addr == input_capture_pkg::IRQ_STAT_ADDR;
   wire       en_sel   = bus_addr == input_capture_pkg::IRQ_EN_ADDR;
   wire       clr_sel  = bus_addr == input_capture_pkg::IRQ_CLR_ADDR;
   wire       low_power = cpu_idle | cpu_sleep;

   logic [15:0]             ctrl_view [NUM_CHANNELS];
   logic [15:0]             head_word [NUM_CHANNELS];
   logic [NUM_CHANNELS-1:0] irq_ev;
   logic [NUM_CHANNELS-1:0] wake_ev;
   logic [NUM_CHANNELS-1:0] irq_stat_q;
   logic [NUM_CHANNELS-1:0] irq_en_q;

   ////////////////////////////////////////////////////////////////////////////
   // Channels

   for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_ch   // see RULE_16
      logic [2:0]       sync_q;
      logic             lvl_q;
      logic [15:0]      ctrl_q;
      logic [3:0]       pre_q;
      logic [1:0]       ici_q;
      logic             ovf_q;
      logic [CNT_W-1:0] cnt_q;
      logic [PTR_W-1:0] wptr_q;
      logic [PTR_W-1:0] rptr_q;
      logic [15:0]      fifo_q [FIFO_DEPTH];

      wire [5:0] sel_idx = 6'(c);
      wire       my_ch   = ch_sel == sel_idx[4:0];
      wire [2:0] mode    = ctrl_q[2:0];
      wire [1:0] cpi     = ctrl_q[input_capture_pkg::CPI_LSB +: 2];
      wire       idle_stop = ctrl_q[input_capture_pkg::IDLE_STOP_BIT];
      wire       tb_sel  = ctrl_q[input_capture_pkg::TB_SEL_BIT];

      // Level accepted once the second and third stages agree
      wire lvl_new = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
      wire rise    = lvl_new & ~lvl_q;
      wire fall    = ~lvl_new & lvl_q;

      wire is_off  = (mode == input_capture_pkg::MODE_OFF)
                   | (mode == input_capture_pkg::MODE_UNUSED);          // see RULE_05
      wire is_wake = mode == input_capture_pkg::MODE_WAKE;
      wire is_div  = (mode == input_capture_pkg::MODE_DIV4)
                   | (mode == input_capture_pkg::MODE_DIV16);
      wire halted  = idle_stop & cpu_idle;                               // see RULE_13
      wire active  = ~is_off & ~is_wake & ~halted;
      wire pre_tc  = (mode == input_capture_pkg::MODE_DIV4)
                   ? (pre_q == input_capture_pkg::PRE_TC_4)
                   : (pre_q == input_capture_pkg::PRE_TC_16);           // see RULE_03
      wire cap_ev  = active & edge_hit(mode, rise, fall, pre_tc);       // see RULE_01
      wire full    = cnt_q == FULL_CNT;
      wire push    = cap_ev & ~full;                                     // see RULE_18
      wire pop     = bus_rd & buf_sel & my_ch & (cnt_q != '0);          // see RULE_17
      wire every   = mode == input_capture_pkg::MODE_EVERY;
      wire ici_hit = every | (ici_q == cpi);                             // see RULE_08
      wire [15:0] stamp = tb_sel ? time_base_a_count : time_base_b_count; // see RULE_12

      assign irq_ev[c]  = is_wake ? (rise & low_power)                   // see RULE_06
                                  : (cap_ev & ici_hit);                  // see RULE_07
      assign wake_ev[c] = low_power & (is_wake ? rise : cap_ev);         // see RULE_14
      assign head_word[c] = fifo_q[rptr_q];
      assign ctrl_view[c] = ctrl_q
                          | (16'(ovf_q) << input_capture_pkg::OVF_BIT)   // see RULE_11
                          | (16'(cnt_q != '0) << input_capture_pkg::BNE_BIT); // see RULE_10

      // Pin synchroniser; only the edge detector looks past the first stage
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            sync_q <= 3'h0;
         end else if (clk_en) begin
            sync_q <= {sync_q[1:0], capture_input_pin[c]};
         end
      end

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            lvl_q <= 1'b0;
         end else if (clk_en) begin
            lvl_q <= lvl_new;
         end
      end

      wire ctrl_we = bus_wr & ctrl_sel & my_ch;

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            ctrl_q <= input_capture_pkg::CTRL_RESET;
         end else if (clk_en && ctrl_we) begin
            ctrl_q <= bus_wdata & input_capture_pkg::CTRL_WR_MASK;
         end
      end

      /////////////////////////////////////////////////////////////////////////
      // Next-state selection

      // Prescaler restarts whenever the channel leaves a divided mode
      wire [3:0] pre_d = (!is_div || is_off) ? 4'h0
                       : !(active && rise)   ? pre_q
                       : pre_tc              ? 4'h0
                       : pre_q + 4'h1;                                       // see RULE_03

      // Capture count restarts where the count field does not apply
      wire [1:0] ici_d = (is_off || is_wake || every) ? 2'h0
                       : !cap_ev                      ? ici_q
                       : ici_hit                      ? 2'h0
                       : ici_q + 2'h1;                                       // see RULE_07

      // Switching the channel off flushes the buffer
      wire [PTR_W-1:0] wptr_d = is_off ? '0 : (push ? ptr_inc(wptr_q) : wptr_q);
      wire [PTR_W-1:0] rptr_d = is_off ? '0 : (pop ? ptr_inc(rptr_q) : rptr_q); // see RULE_17
      wire [CNT_W-1:0] cnt_d  = is_off ? '0 : cnt_step(cnt_q, push, pop);

      // Overflow stays set until the channel is switched off
      wire ovf_d = ~is_off & (ovf_q | (cap_ev & full)); // see RULE_11, RULE_18

      /////////////////////////////////////////////////////////////////////////
      // Channel state

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            pre_q <= 4'h0;
         end else if (clk_en) begin
            pre_q <= pre_d;
         end
      end

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            ici_q <= 2'h0;
         end else if (clk_en) begin
            ici_q <= ici_d;
         end
      end

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            wptr_q <= '0;
         end else if (clk_en) begin
            wptr_q <= wptr_d;
         end
      end

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            rptr_q <= '0;
         end else if (clk_en) begin
            rptr_q <= rptr_d;
         end
      end

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            cnt_q <= '0;
         end else if (clk_en) begin
            cnt_q <= cnt_d;
         end
      end

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            ovf_q <= 1'b0;
         end else if (clk_en) begin
            ovf_q <= ovf_d;
         end
      end

      // Storage is not reset; pushes are guarded by full and pops by empty, an empty read returns the word at the read pointer
      always_ff @(posedge core_clk) begin
         if (clk_en && push) begin
            fifo_q[wptr_q] <= stamp;                                   // see RULE_09
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, enable and clear

   wire                    clr_wr   = bus_wr & clr_sel;
   wire [NUM_CHANNELS-1:0] clr_mask = clr_wr ? bus_wdata[NUM_CHANNELS-1:0] : '0;
   // A new event wins over a clear in the same cycle
   wire [NUM_CHANNELS-1:0] stat_d   = (irq_stat_q & ~clr_mask) | irq_ev;
   wire                    en_we    = bus_wr & en_sel;
   wire [NUM_CHANNELS-1:0] en_d     = en_we ? bus_wdata[NUM_CHANNELS-1:0] : irq_en_q;
   // Interrupt is registered from the next status in the same cycle, through the enable in force
   wire                    irq_d    = |(stat_d & irq_en_q);
   wire                    wake_d   = |wake_ev;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_q <= '0;
      end else if (clk_en) begin
         irq_stat_q <= stat_d;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_en_q <= '0;
      end else if (clk_en) begin
         irq_en_q <= en_d;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_q <= 1'b0;
      end else if (clk_en) begin
         irq_q <= irq_d;                                               // see RULE_07
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wake_q <= 1'b0;
      end else if (clk_en) begin
         wake_q <= wake_d;                                             // see RULE_14
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   wire [15:0] ch_rd   = buf_sel ? head_word[ch_sel[2:0]] : ctrl_view[ch_sel[2:0]];
   wire [15:0] rd_mux  = (ctrl_sel | buf_sel) ? ch_rd
                       : stat_sel ? 16'(irq_stat_q)
                       : en_sel   ? 16'(irq_en_q)
                       : 16'h0000;
   wire [15:0] rdata_d = bus_rd ? rd_mux : 16'h0000;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         bus_rdata_q <= 16'h0000;
      end else if (clk_en) begin
         bus_rdata_q <= rdata_d;
      end
   end

endmodule : input_capture

/* File: tb/input_capture_monitor.sv */
// Checker for the capture block's register port, interrupt and wake outputs.
// Assumes one clock domain; bound to every input_capture instance.
module input_capture_monitor (
   input wire logic        core_clk,    // Clock
   input wire logic        rstn,        // Reset, active low
   input wire logic        clk_en,      // Clock enable
   input wire logic        cpu_idle,    // CPU idle
   input wire logic        cpu_sleep,   // CPU sleep
   input wire logic [7:0]  bus_addr,    // Address
   input wire logic [15:0] bus_wdata,   // Write data
   input wire logic        bus_wr,      // Write strobe
   input wire logic        bus_rd,      // Read strobe
   input wire logic [15:0] bus_rdata_q, // Read data
   input wire logic        irq_q,       // Interrupt
   input wire logic        wake_q       // Wake pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] en_q; // Shadow of the enable register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) en_q <= 8'h00;
      else if (clk_en && bus_wr && bus_addr == input_capture_pkg::IRQ_EN_ADDR)
         en_q <= bus_wdata[7:0];
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////
   chk_rdata_idle : assert property (
      $past(clk_en) && !$past(bus_rd) |-> bus_rdata_q == 16'h0000)
      else $error("read data not zero outside a read");
   chk_unmapped_zero : assert property (
      $past(clk_en && bus_rd && bus_addr >= 8'h4c) |-> bus_rdata_q == 16'h0000)
      else $error("unmapped read not zero");
   chk_ctrl_unused : assert property (
      $past(clk_en && bus_rd && bus_addr < 8'h40 && !bus_addr[2])
      |-> (bus_rdata_q & 16'hdf00) == 16'h0000) else $error("control spare bits set");
   chk_status_width : assert property (
      $past(clk_en && bus_rd && bus_addr == input_capture_pkg::IRQ_STAT_ADDR)
      |-> bus_rdata_q[15:8] == 8'h00) else $error("status upper bits set");
   chk_clear_reads : assert property (
      $past(clk_en && bus_rd && bus_addr == input_capture_pkg::IRQ_CLR_ADDR)
      |-> bus_rdata_q == 16'h0000) else $error("clear register read not zero");
   chk_irq_enabled : assert property (
      irq_q |-> $past(en_q) != 8'h00) else $error("interrupt with all sources masked");
   chk_irq_masked : assert property (
      clk_en && bus_wr && bus_addr == input_capture_pkg::IRQ_EN_ADDR
      && bus_wdata[7:0] == 8'h00 |-> ##2 !irq_q) else $error("interrupt not masked");
   chk_wake_mode : assert property (
      wake_q |-> $past(cpu_idle || cpu_sleep)) else $error("wake outside sleep or idle");
   cover property (wake_q);
   cover property ($rose(irq_q));
   cover property (bus_rd && bus_addr == input_capture_pkg::CH_BUF_OFS);
endmodule : input_capture_monitor

bind input_capture input_capture_monitor input_capture_monitor_inst (
   .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .cpu_idle(cpu_idle),
   .cpu_sleep(cpu_sleep), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
   .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q), .irq_q(irq_q), .wake_q(wake_q));

/* File: tb/pin_source.sv */
// Model of the capture pins and the two timer time bases.
// Assumes the bench calls put_edge from one process at a time.
module pin_source (
   input  wire logic        core_clk,          // Clock
   output logic      [7:0]  capture_input_pin, // Pin levels
   output logic      [15:0] time_base_a_count, // First time base
   output logic      [15:0] time_base_b_count  // Second time base
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      capture_input_pin = 8'h00;
      time_base_a_count = 16'h0000;
      time_base_b_count = 16'hffff;
   end
   task automatic put_edge(input int ch, input logic lvl, input logic [15:0] a);
      @(posedge core_clk);
      time_base_a_count      <= a;
      time_base_b_count      <= ~a;
      capture_input_pin[ch]  <= lvl;
      // Counts held across the synchroniser so the stored value is known
      repeat (8) @(posedge core_clk);
   endtask : put_edge
endmodule : pin_source

/* File: tb/test_input_capture.sv */
// Bench for the capture block: bus tasks, pin model and self-checks.
// Assumes pin_source drives pins and time bases; clk_en low only when frozen.
module test_input_capture;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0, rstn = 1'b0, cpu_idle = 1'b0, cpu_sleep = 1'b0;
   logic        bus_wr = 1'b0, bus_rd = 1'b0, clk_en = 1'b1, irq_q, wake_q;
   logic [7:0]  bus_addr = 8'h00, pins;
   logic [15:0] bus_wdata = 16'h0000, nwake = 16'h0000, w0, bus_rdata_q, ta, tb;
   int          errors = 0, n_compared = 0, n;
   input_capture input_capture_inst (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
      .capture_input_pin(pins), .time_base_a_count(ta), .time_base_b_count(tb),
      .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata_q(bus_rdata_q), .irq_q(irq_q), .wake_q(wake_q));
   pin_source pin_source_inst (.core_clk(core_clk), .capture_input_pin(pins),
      .time_base_a_count(ta), .time_base_b_count(tb));
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (wake_q === 1'b1) nwake <= nwake + 16'h0001;
   ////////////////////////////////////////
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge core_clk);
      bus_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      #1 cmp(bus_rdata_q, exp);
   endtask : rd
   task automatic pulse(input int ch, input logic [15:0] a);
      pin_source_inst.put_edge(ch, 1'b1, a);
      pin_source_inst.put_edge(ch, 1'b0, a);
   endtask : pulse
   task automatic end_sim;
      $display("compared=%0d errors=%0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   initial begin
      #200us;
      errors++;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      rd(8'h00, 16'h0000);
      rd(8'h4c, 16'h0000);
      wr(8'h00, 16'hffff);
      rd(8'h00, 16'h20e7);
      for (int m = 1; m <= 3; m++) begin
         wr(8'h00, {8'h00, m[0], 4'h0, m[2:0]});
         pin_source_inst.put_edge(0, 1'b1, 16'h1100);
         pin_source_inst.put_edge(0, 1'b0, 16'h2200);
         rd(8'h04, (m == 2) ? 16'hddff : 16'h1100);
         if (m == 1) rd(8'h04, 16'h2200);
         rd(8'h00, {8'h00, m[0], 4'h0, m[2:0]});
      end
      $display("edge modes done");
      for (int m = 4; m <= 5; m++) begin
         n = (m == 4) ? 4 : 16;
         wr(8'h10, 16'h0080 | m[15:0]);
         for (int k = 1; k <= n; k++) begin
            if (k == n) rd(8'h10, 16'h0080 | m[15:0]);
            pulse(2, k[15:0]);
         end
         rd(8'h14, n[15:0]);
         wr(8'h10, 16'h0000);
      end
      $display("prescaler done");
      wr(8'h38, 16'h0083);
      for (int k = 0; k < 5; k++) pulse(7, 16'h0700 + k[15:0]);
      rd(8'h38, 16'h009b);
      for (int k = 0; k < 4; k++) rd(8'h3c, 16'h0700 + k[15:0]);
      rd(8'h38, 16'h0093);
      wr(8'h38, 16'h0000);
      rd(8'h38, 16'h0000);
      for (int m = 0; m <= 6; m += 6) begin
         wr(8'h00, m[15:0]);
         pulse(0, 16'h0606);
         rd(8'h00, m[15:0]);
      end
      wr(8'h00, 16'h0083);
      clk_en <= 1'b0;
      wr(8'h00, 16'h0000);
      pulse(0, 16'h0505);
      @(posedge core_clk) clk_en <= 1'b1;
      rd(8'h00, 16'h0083);
      $display("overflow and off done");
      wr(8'h48, 16'h00ff);
      wr(8'h44, 16'h0001);
      wr(8'h00, 16'h00a3);
      pulse(0, 16'h0001);
      cmp({15'h0000, irq_q}, 16'h0000);
      pulse(0, 16'h0002);
      cmp({15'h0000, irq_q}, 16'h0001);
      rd(8'h40, 16'h0001);
      wr(8'h48, 16'h0001);
      repeat (2) @(posedge core_clk);
      #1 cmp({15'h0000, irq_q}, 16'h0000);
      wr(8'h00, 16'h0061);
      pulse(0, 16'h0003);
      cmp({15'h0000, irq_q}, 16'h0001);
      wr(8'h44, 16'h0000);
      wr(8'h48, 16'h00ff);
      wr(8'h00, 16'h0000);
      $display("interrupt done");
      @(posedge core_clk) cpu_sleep <= 1'b1;
      w0 = nwake;
      wr(8'h00, 16'h0007);
      pulse(0, 16'h0007);
      rd(8'h40, 16'h0001);
      rd(8'h00, 16'h0007);
      wr(8'h48, 16'h00ff);
      @(posedge core_clk) cpu_sleep <= 1'b0;
      pulse(0, 16'h0008);
      rd(8'h40, 16'h0000);
      @(posedge core_clk) cpu_idle <= 1'b1;
      wr(8'h00, 16'h2083);
      pulse(0, 16'h3333);
      rd(8'h00, 16'h2083);
      wr(8'h00, 16'h0083);
      pulse(0, 16'h4444);
      rd(8'h04, 16'h4444);
      cmp(nwake - w0, 16'h0002);
      @(posedge core_clk) cpu_idle <= 1'b0;
      $display("sleep and idle done");
      end_sim;
   end
endmodule : test_input_capture
